// >>> rtl/pmcs_defines.vh
`ifndef PMCS_DEFINES_VH
`define PMCS_DEFINES_VH

// Port modes
`define PMCS_MODE_W 2
`define PMCS_MODE_UNATT 2'h0
`define PMCS_MODE_UP 2'h1
`define PMCS_MODE_DOWN 2'h2
`define PMCS_MODE_DIS 2'h3

// Change action select
`define PMCS_ACT_W 2
`define PMCS_ACT_NONE 2'h0
`define PMCS_ACT_RESET 2'h1
`define PMCS_ACT_HOT 2'h2

// Reset values
`define PMCS_PART_RST 4'h0
`define PMCS_DEVICE_NUMBER_FIELD_RST 5'h00

// Latency
`define PMCS_CLK_KHZ 40000
`define PMCS_LAT_NONE_US 2000
`define PMCS_LAT_RESET_US 2500
`define PMCS_LAT_NONE_CYC (`PMCS_LAT_NONE_US * `PMCS_CLK_KHZ / 1000)
`define PMCS_LAT_RESET_CYC (`PMCS_LAT_RESET_US * `PMCS_CLK_KHZ / 1000)

`endif

// >>> rtl/pmcs_timer.v
`timescale 1ns/1ps
`include "pmcs_defines.vh"

module pmcs_timer #(
  parameter CW = 17
) (
  clk,
  nrst,
  start,
  load,
  done
);
  input wire clk;
  input wire nrst;
  input wire start;
  input wire [CW-1:0] load;
  output reg done;

  reg [CW-1:0] cnt_r;
  reg run_r;

  always @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= {CW{1'b0}};
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      // Done holds until the next start, so a slow add step cannot strand the wait
      if (start) begin
        cnt_r <= load;
        run_r <= 1'b1;
        done <= 1'b0;
      end else if (run_r) begin
        if (cnt_r <= {{(CW-1){1'b0}}, 1'b1}) begin
          run_r <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // pmcs_timer

// >>> rtl/pmcs_seq.v
`timescale 1ns/1ps
`include "pmcs_defines.vh"

// Behaviour
// (RULE_01) The requester waits for the completion flag before another change on the port or its partition.
// (RULE_02) The requester never turns a former upstream port into a downstream port before a fundamental reset.
// (RULE_03) The requester never turns a former downstream port into an upstream port before a fundamental reset.
// (RULE_04) The requester does not change an attached port's mode while its partition's state changes.
// (RULE_05) The requester does not add a port to a partition whose state is changing.
// (RULE_06) The requester sets both next-capability pointers for upstream use before unattached to upstream.
// (RULE_07) Unattached/downstream changes use reset or no action, and no action needs a full retrain afterwards.
// (RULE_08) During a partition reset-pin fundamental reset an outside port joins only with no action.
// (RULE_09) During a partition hot reset an outside port joins only with no action.
// (RULE_10) The requester keeps the port free of traffic for the whole change.
// (RULE_11) Each change is classed as removal, addition, both or neither, and each part is carried out.
// (RULE_12) A mode change inside one partition is a full removal and then a full re-addition.
// (RULE_13) A device number change alone is removal, number update, then re-addition.
// (RULE_14) Steps run strictly as started flag, removal, addition, port action, completed flag.
// (RULE_15) A change starts on any new mode, partition or device number value, or on partition disable.
// (RULE_16) A change completes in 2 ms with no action and 2.5 ms with reset.
// (RULE_17) Both flags stay set until software clears them.

module pmcs_seq #(
  parameter PW = 4,
  parameter DW = 5,
  parameter CW = 17,
  parameter LAT_NONE = `PMCS_LAT_NONE_CYC,
  parameter LAT_RESET = `PMCS_LAT_RESET_CYC
) (
  clk,
  nrst,
  cfg_mode,
  cfg_part,
  cfg_device_number_field,
  change_action_select,
  part_disable,
  flag_clear,
  remove_ack,
  add_ack,
  change_started_flag,
  change_completed_flag,
  busy,
  remove_req,
  remove_part,
  add_req,
  add_part,
  port_reset,
  cur_mode,
  cur_part,
  cur_device_number_field
);
  input wire clk;
  input wire nrst;
  input wire [`PMCS_MODE_W-1:0] cfg_mode;
  input wire [PW-1:0] cfg_part;
  input wire [DW-1:0] cfg_device_number_field;
  input wire [`PMCS_ACT_W-1:0] change_action_select;
  input wire part_disable;
  input wire [1:0] flag_clear;
  input wire remove_ack;
  input wire add_ack;
  output reg change_started_flag;
  output reg change_completed_flag;
  output wire busy;
  output reg remove_req;
  output reg [PW-1:0] remove_part;
  output reg add_req;
  output reg [PW-1:0] add_part;
  output reg port_reset;
  output reg [`PMCS_MODE_W-1:0] cur_mode;
  output reg [PW-1:0] cur_part;
  output reg [DW-1:0] cur_device_number_field;

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_REM = 6'h02;
  localparam [5:0] S_UPD = 6'h04;
  localparam [5:0] S_ADD = 6'h08;
  localparam [5:0] S_ACT = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg dis_d_r;
  reg [`PMCS_ACT_W-1:0] act_r;
  reg [`PMCS_MODE_W-1:0] new_mode_r;
  reg [PW-1:0] new_part_r;
  reg [DW-1:0] new_device_number_field_r;
  reg do_rem_r;
  reg do_add_r;
  reg tmr_start;
  wire tmr_done;
  wire [CW-1:0] tmr_load;

  // Only attached modes belong to a partition
  wire old_att = (cur_mode == `PMCS_MODE_UP) || (cur_mode == `PMCS_MODE_DOWN);
  wire new_att = (cfg_mode == `PMCS_MODE_UP) || (cfg_mode == `PMCS_MODE_DOWN);
  wire cfg_diff = (cfg_mode != cur_mode) || (cfg_part != cur_part) || (cfg_device_number_field != cur_device_number_field);
  // Only a rising disable starts a change; staying disabled does not
  wire dis_rise = part_disable && !dis_d_r;
  wire trig = cfg_diff || dis_rise; // [RULE_15]

  // Latency is counted from the last S_REM cycle, as S_REM restarts the timer every cycle
  assign tmr_load = (act_r == `PMCS_ACT_RESET) ? LAT_RESET[CW-1:0] : LAT_NONE[CW-1:0]; // [RULE_16]
  assign busy = (state_r != S_IDLE);

  pmcs_timer #(.CW(CW)) u_tmr (
    .clk(clk),
    .nrst(nrst),
    .start(tmr_start),
    .load(tmr_load),
    .done(tmr_done)
  );

  always @* begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (trig) begin
          state_nxt = S_REM;
        end
      end
      S_REM: begin
        tmr_start = 1'b1;
        if (!do_rem_r || remove_ack) begin
          state_nxt = S_UPD; // [RULE_14]
        end
      end
      S_UPD: state_nxt = S_ADD; // [RULE_13]
      S_ADD: begin
        if (!do_add_r || add_ack) begin
          state_nxt = S_ACT; // [RULE_14]
        end
      end
      S_ACT: state_nxt = S_WAIT;
      // Timer done is a level, so a late add step only shortens this wait
      S_WAIT: begin
        if (tmr_done) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      dis_d_r <= 1'b0;
      act_r <= `PMCS_ACT_NONE;
      new_mode_r <= `PMCS_MODE_UNATT;
      new_part_r <= `PMCS_PART_RST;
      new_device_number_field_r <= `PMCS_DEVICE_NUMBER_FIELD_RST;
      do_rem_r <= 1'b0;
      do_add_r <= 1'b0;
      change_started_flag <= 1'b0;
      change_completed_flag <= 1'b0;
      remove_req <= 1'b0;
      remove_part <= `PMCS_PART_RST;
      add_req <= 1'b0;
      add_part <= `PMCS_PART_RST;
      port_reset <= 1'b0;
      cur_mode <= `PMCS_MODE_UNATT;
      cur_part <= `PMCS_PART_RST;
      cur_device_number_field <= `PMCS_DEVICE_NUMBER_FIELD_RST;
    end else begin
      state_r <= state_nxt;
      dis_d_r <= part_disable;
      port_reset <= 1'b0;
      // Set wins over a clear in the same cycle
      if (state_r == S_IDLE && trig) begin
        change_started_flag <= 1'b1; // [RULE_14]
      end else if (flag_clear[0]) begin
        change_started_flag <= 1'b0; // [RULE_17]
      end
      if (state_r == S_WAIT && tmr_done) begin
        change_completed_flag <= 1'b1; // [RULE_14]
      end else if (flag_clear[1]) begin
        change_completed_flag <= 1'b0; // [RULE_17]
      end
      case (state_r)
        S_IDLE: begin
          if (trig) begin
            // Inputs are captured once; later edits wait for the next idle cycle
            act_r <= change_action_select;
            new_mode_r <= cfg_mode;
            new_part_r <= cfg_part;
            new_device_number_field_r <= cfg_device_number_field;
            // Same-partition changes still leave and rejoin in full
            do_rem_r <= old_att; // [RULE_11] [RULE_12]
            do_add_r <= new_att && !part_disable; // [RULE_11] [RULE_12]
            remove_part <= cur_part;
            remove_req <= old_att;
          end
        end
        S_REM: begin
          if (remove_ack) begin
            remove_req <= 1'b0;
          end
        end
        S_UPD: begin
          cur_mode <= new_mode_r;
          cur_part <= new_part_r;
          cur_device_number_field <= new_device_number_field_r; // [RULE_13]
          add_part <= new_part_r;
          add_req <= do_add_r;
        end
        S_ADD: begin
          if (add_ack) begin
            add_req <= 1'b0;
          end
        end
        S_ACT: begin
          port_reset <= (act_r != `PMCS_ACT_NONE); // [RULE_14]
        end
        default: begin
        end
      endcase
    end
  end
endmodule // pmcs_seq

// >>> test/pmcs_monitor.sv
`timescale 1ns/1ps
module pmcs_monitor #(
  parameter int LAT_RESET = 25
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] change_action_select,
  input wire logic [1:0] flag_clear,
  input wire logic change_started_flag,
  input wire logic change_completed_flag,
  input wire logic busy,
  input wire logic remove_req,
  input wire logic add_req,
  input wire logic port_reset
);
  // Slack for ack handshakes on top of the longest latency
  localparam int LMAX = LAT_RESET + 8;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence removal_done_s;
    remove_req ##1 !remove_req;
  endsequence
  start_flag_a: assert property ($rose(busy) |-> change_started_flag)
    else $error("started flag missing at change start");
  step_order_a: assert property (add_req |-> !remove_req)
    else $error("addition overlaps removal");
  done_idle_a: assert property ($rose(change_completed_flag) |-> !busy && !remove_req && !add_req)
    else $error("completed flag before steps ended");
  hold_started_a: assert property (change_started_flag && !flag_clear[0] |=> change_started_flag)
    else $error("started flag dropped");
  hold_done_a: assert property (change_completed_flag && !flag_clear[1] |=> change_completed_flag)
    else $error("completed flag dropped");
  reset_pulse_a: assert property (port_reset |=> !port_reset)
    else $error("port reset longer than one cycle");
  no_action_a: assert property (busy && change_action_select == 2'h0 |-> !port_reset)
    else $error("port reset with no action");
  latency_cap_a: assert property (removal_done_s |-> ##[0:LMAX] !busy)
    else $error("change did not finish in time");
endmodule // pmcs_monitor

bind pmcs_seq pmcs_monitor #(.LAT_RESET(LAT_RESET)) u_pmcs_monitor (.clk(clk), .nrst(nrst),
  .change_action_select(change_action_select), .flag_clear(flag_clear), .change_started_flag(change_started_flag),
  .change_completed_flag(change_completed_flag), .busy(busy), .remove_req(remove_req), .add_req(add_req),
  .port_reset(port_reset));

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 0, nrst = 0, part_disable = 0, remove_ack = 0, add_ack = 0;
  logic [1:0] cfg_mode = 0, change_action_select = 0, flag_clear = 0;
  logic [3:0] cfg_part = 0;
  logic [4:0] cfg_device_number_field = 0;
  wire change_started_flag, change_completed_flag, busy, remove_req, add_req, port_reset;
  wire [1:0] cur_mode;
  wire [3:0] cur_part;
  wire [4:0] cur_device_number_field;
  wire [3:0] remove_part, add_part;
  logic [3:0] seen_rp = 0, seen_ap = 0;
  int errors = 0, n_checks = 0, n_rem, n_add, n_rst, cyc = 0;
  pmcs_seq #(.LAT_NONE(20), .LAT_RESET(25)) u_pmcs_seq (.clk(clk), .nrst(nrst), .cfg_mode(cfg_mode),
    .cfg_part(cfg_part), .cfg_device_number_field(cfg_device_number_field), .change_action_select(change_action_select),
    .part_disable(part_disable), .flag_clear(flag_clear), .remove_ack(remove_ack), .add_ack(add_ack),
    .change_started_flag(change_started_flag), .change_completed_flag(change_completed_flag), .busy(busy),
    .remove_req(remove_req), .remove_part(remove_part), .add_req(add_req), .add_part(add_part), .port_reset(port_reset),
    .cur_mode(cur_mode), .cur_part(cur_part), .cur_device_number_field(cur_device_number_field));
  initial forever #12.5 clk = ~clk;
  // Partition side acks each request at once and counts the steps
  always @(posedge clk) begin
    remove_ack <= remove_req & ~remove_ack;
    add_ack <= add_req & ~add_ack;
    if (remove_req & ~remove_ack) begin
      n_rem++;
      seen_rp = remove_part;
    end
    if (add_req & ~add_ack) begin
      n_add++;
      seen_ap = add_part;
    end
    if (port_reset) n_rst++;
    cyc++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task run(input [1:0] m, input [3:0] p, input [4:0] d, input [1:0] a, input pd, input er, input ea, input es);
    int t, lat;
    logic [3:0] old_p;
    @(posedge clk);
    flag_clear <= 2'h3;
    {cfg_mode, cfg_part, cfg_device_number_field, change_action_select, part_disable} <= {m, p, d, a, pd};
    n_rem = 0;
    n_add = 0;
    n_rst = 0;
    old_p = cur_part;
    // Only the reset action carries the longer latency
    lat = (a == 2'h1) ? 25 : 20;
    @(posedge clk);
    flag_clear <= 2'h0;
    #1;
    t = 1;
    // Traffic is taken as held off until the completed flag is seen
    while (change_completed_flag !== 1'b1 && t < 200) begin
      @(posedge clk);
      #1;
      t++;
    end
    repeat (3) @(posedge clk);
    #1;
    check({change_started_flag, change_completed_flag}, 2'h3);
    check({n_rem != 0, n_add != 0, n_rst != 0}, {er, ea, es});
    check(t >= lat && t <= lat + 8, 1);
    check({cur_mode, cur_part, cur_device_number_field}, {m, p, d});
    if (er) check(seen_rp, old_p);
    if (ea) check(seen_ap, p);
    $display("test done at %0t", $time);
  endtask
  task same_value();
    @(posedge clk);
    flag_clear <= 2'h3;
    part_disable <= 1'b0;
    {cfg_mode, cfg_part, cfg_device_number_field} <= {2'h3, 4'h2, 5'h00};
    @(posedge clk);
    flag_clear <= 2'h0;
    repeat (6) @(posedge clk);
    #1;
    check({busy, change_started_flag, change_completed_flag}, 3'h0);
    $display("same value test done");
  endtask
  task fund_reset();
    @(posedge clk);
    nrst <= 1'b0;
    {cfg_mode, cfg_part, cfg_device_number_field, change_action_select, part_disable} <= 14'h0000;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    check({busy, change_started_flag, change_completed_flag, remove_req, add_req, port_reset}, 6'h00);
    check({cur_mode, cur_part, cur_device_number_field}, 11'h000);
    $display("reset test done");
  endtask
  task unatt_to_down();
    run(2'h2, 4'h1, 5'h01, 2'h1, 0, 0, 1, 1);
  endtask
  task device_number_field_only();
    run(2'h2, 4'h1, 5'h03, 2'h1, 0, 1, 1, 1);
  endtask
  task down_to_unatt();
    run(2'h0, 4'h0, 5'h03, 2'h0, 0, 1, 0, 0);
  endtask
  task unatt_to_up();
    run(2'h1, 4'h2, 5'h00, 2'h2, 0, 0, 1, 1);
  endtask
  task part_disabled();
    run(2'h1, 4'h2, 5'h00, 2'h2, 1, 1, 0, 1);
  endtask
  task mode_disabled();
    run(2'h3, 4'h2, 5'h00, 2'h0, 1, 1, 0, 0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    unatt_to_down();
    device_number_field_only();
    down_to_unatt();
    fund_reset();
    unatt_to_up();
    part_disabled();
    mode_disabled();
    same_value();
    final_report();
  end
endmodule // tb
